/* design/sswd_regs.svh */
`ifndef SSWD_REGS_SVH
`define SSWD_REGS_SVH

`define SSWD_ADDR_W          4
`define SSWD_OFF_RST_PERIOD  4'h0
`define SSWD_OFF_WDU_PERIOD  4'h4
`define SSWD_OFF_STATUS      4'h8

`define SSWD_ST_RESET_N      0
`define SSWD_ST_FAULT_N      1
`define SSWD_ST_VOLT_OK      2
`define SSWD_ST_TIMEOUT_MODE 3
`define SSWD_ST_WD_OFF       4
`define SSWD_ST_BLANK        5

`define SSWD_CLK_MHZ         50
`define SSWD_RST_PERIOD_NS   25000
`define SSWD_WDU_PERIOD_NS   200000
`define SSWD_BLANK_NS        1000
`define SSWD_FILT_NS         320
`define SSWD_LOWER_RATIO     32'h0000001F
`define SSWD_EARLY_LIMIT     2'h2
`define SSWD_KICK_SETTLE     3'h5

`define SSWD_RST_CYCLES   ((`SSWD_RST_PERIOD_NS * `SSWD_CLK_MHZ + 999) / 1000)
`define SSWD_WDU_CYCLES   ((`SSWD_WDU_PERIOD_NS * `SSWD_CLK_MHZ + 999) / 1000)
`define SSWD_BLANK_CYCLES ((`SSWD_BLANK_NS * `SSWD_CLK_MHZ + 999) / 1000)
`define SSWD_FILT_CYCLES  ((`SSWD_FILT_NS * `SSWD_CLK_MHZ + 999) / 1000)

`endif

/* design/sswd_pkg.sv */
package sswd_pkg;

	typedef enum logic [1:0] {
		SSWD_POR_HOLD = 2'h0,
		SSWD_POR_TIME = 2'h1,
		SSWD_POR_RUN  = 2'h3
	} sswd_por_e;

	typedef enum logic [1:0] {
		SSWD_WD_IDLE  = 2'h0,
		SSWD_WD_WATCH = 2'h1,
		SSWD_WD_FAULT = 2'h3
	} sswd_wd_e;

endpackage

/* design/sswd_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module sswd_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] level_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					s1_q         <= 1'b0;
					s2_q         <= 1'b0;
					s3_q         <= 1'b0;
					level_out[i] <= 1'b0;
				end
				else
				begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// Change accepted only once two late stages agree
					if (s2_q == s3_q)
						level_out[i] <= s3_q;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* design/sswd_filter.sv */
`timescale 1ns/10ps
`default_nettype none

module sswd_filter #(
	parameter int CYCLES = 16
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic raw_ok,
	output logic      filt_ok
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] TOP = CW'(CYCLES);

	logic [CW-1:0] level_q;

	// Integrator: short glitches never reach either rail
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			level_q <= '0;
			filt_ok <= 1'b0;
		end
		else
		begin
			if (raw_ok && level_q != TOP)
				level_q <= level_q + 1'b1;
			else if (!raw_ok && level_q != '0)
				level_q <= level_q - 1'b1;
			if (level_q == TOP)
				filt_ok <= 1'b1;
			else if (level_q == '0)
				filt_ok <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* design/sswd_top.sv */
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "sswd_regs.svh"

module sswd_top #(
	parameter int WDU_CYCLES   = `SSWD_WDU_CYCLES,
	parameter int RST_CYCLES   = `SSWD_RST_CYCLES,
	parameter int BLANK_CYCLES = `SSWD_BLANK_CYCLES,
	parameter int FILT_CYCLES  = `SSWD_FILT_CYCLES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   feedback_sense_above,
	input  wire logic                   kick_input,
	input  wire logic                   watchdog_off_select,
	input  wire logic                   timeout_mode_select,
	output logic                        reset_out_n,
	output logic                        watchdog_fault_out_n,
	input  wire logic [`SSWD_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest
);

	logic [3:0]          sync_lv;
	logic                kick_s;
	logic                wd_off_s;
	logic                timeout_s;
	logic                raw_ok_s;
	logic                volt_ok;
	logic                kick_prev_q;
	logic                kick_any;
	logic                kick_fall;
	logic                kick_ok;
	logic [2:0]          arm_cnt_q;
	logic                kick_armed;
	logic [31:0]         rst_period_q;
	logic [31:0]         wdu_period_q;
	logic [31:0]         lower_period;
	sswd_pkg::sswd_por_e por_q;
	logic [31:0]         por_cnt_q;
	logic                rst_drop;
	logic                rst_ok;
	sswd_pkg::sswd_wd_e  wd_q;
	logic [31:0]         wd_cnt_q;
	logic [1:0]          early_q;
	logic                wd_run;
	logic                reset_prev_q;
	logic                fault_prev_q;
	logic                out_rise;
	logic [31:0]         blank_cnt_q;
	logic                blank_active;

	// Pins from outside the clock domain
	sswd_sync #(
		.WIDTH (4)
	) u_sync (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pin_in    ({feedback_sense_above, timeout_mode_select,
		             watchdog_off_select, kick_input}),
		.level_out (sync_lv)
	);

	assign kick_s    = sync_lv[0];
	assign wd_off_s  = sync_lv[1];
	assign timeout_s = sync_lv[2];
	assign raw_ok_s  = sync_lv[3];

	sswd_filter #(
		.CYCLES (FILT_CYCLES)
	) u_filter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.raw_ok  (raw_ok_s),
		.filt_ok (volt_ok)
	);

	// Synchroniser leaves reset low while an idle kick pin sits high, so
	// edges count only once its stages have filled
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			arm_cnt_q <= 3'h0;
		else if (!kick_armed)
			arm_cnt_q <= arm_cnt_q + 3'h1;
	end

	assign kick_armed = (arm_cnt_q == `SSWD_KICK_SETTLE);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			kick_prev_q <= 1'b0;
		else
			kick_prev_q <= kick_s;
	end

	assign kick_any  = kick_armed & (kick_s ^ kick_prev_q);
	assign kick_fall = kick_armed & kick_prev_q & ~kick_s;

	// Window mode listens to falling edges only
	assign kick_ok = !blank_active && (timeout_s ? kick_any : kick_fall);

	// Fixed ratio keeps both bounds tied to one setting
	assign lower_period = wdu_period_q / `SSWD_LOWER_RATIO;

	// Power-on reset
	assign rst_drop = (por_q == sswd_pkg::SSWD_POR_RUN) && !volt_ok;
	assign rst_ok   = reset_out_n && !rst_drop;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			por_q       <= sswd_pkg::SSWD_POR_HOLD;
			por_cnt_q   <= 32'h0;
			reset_out_n <= 1'b0;
		end
		else
		begin
			case (por_q)
				sswd_pkg::SSWD_POR_HOLD:
				begin
					reset_out_n <= 1'b0;
					por_cnt_q   <= 32'h0;
					if (volt_ok)
						por_q <= sswd_pkg::SSWD_POR_TIME;
				end
				sswd_pkg::SSWD_POR_TIME:
				begin
					if (!volt_ok)
					begin
						por_q     <= sswd_pkg::SSWD_POR_HOLD;
						por_cnt_q <= 32'h0;
					end
					else if (por_cnt_q + 32'h1 >= rst_period_q)
					begin
						por_q       <= sswd_pkg::SSWD_POR_RUN;
						reset_out_n <= 1'b1;
						por_cnt_q   <= 32'h0;
					end
					else
						por_cnt_q <= por_cnt_q + 32'h1;
				end
				sswd_pkg::SSWD_POR_RUN:
				begin
					if (!volt_ok)
					begin
						por_q       <= sswd_pkg::SSWD_POR_HOLD;
						reset_out_n <= 1'b0;
					end
				end
				default:
				begin
					por_q       <= sswd_pkg::SSWD_POR_HOLD;
					reset_out_n <= 1'b0;
					por_cnt_q   <= 32'h0;
				end
			endcase
		end
	end

	// Blanking after either output rises
	assign out_rise     = (reset_out_n && !reset_prev_q) ||
	                      (watchdog_fault_out_n && !fault_prev_q);
	assign blank_active = out_rise || (blank_cnt_q != 32'h0);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			reset_prev_q <= 1'b0;
			fault_prev_q <= 1'b1;
			blank_cnt_q  <= 32'h0;
		end
		else
		begin
			reset_prev_q <= reset_out_n;
			fault_prev_q <= watchdog_fault_out_n;
			if (out_rise)
				blank_cnt_q <= 32'(BLANK_CYCLES) - 32'h1;
			else if (blank_cnt_q != 32'h0)
				blank_cnt_q <= blank_cnt_q - 32'h1;
		end
	end

	// Watchdog only runs with reset released and not switched off
	assign wd_run = rst_ok && !wd_off_s;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wd_q                 <= sswd_pkg::SSWD_WD_IDLE;
			wd_cnt_q             <= 32'h0;
			early_q              <= 2'h0;
			watchdog_fault_out_n <= 1'b1;
		end
		else
		begin
			case (wd_q)
				sswd_pkg::SSWD_WD_IDLE:
				begin
					watchdog_fault_out_n <= 1'b1;
					wd_cnt_q             <= 32'h0;
					early_q              <= 2'h0;
					if (wd_run)
						wd_q <= sswd_pkg::SSWD_WD_WATCH;
				end
				sswd_pkg::SSWD_WD_WATCH:
				begin
					if (!wd_run)
						wd_q <= sswd_pkg::SSWD_WD_IDLE;
					else if (kick_ok && timeout_s)
						wd_cnt_q <= 32'h0;
					else if (kick_ok && wd_cnt_q < lower_period)
					begin
						// Too many kicks packed into the lower bound
						if (early_q == `SSWD_EARLY_LIMIT)
						begin
							wd_q                 <= sswd_pkg::SSWD_WD_FAULT;
							watchdog_fault_out_n <= 1'b0;
							wd_cnt_q             <= 32'h0;
						end
						else
							early_q <= early_q + 2'h1;
					end
					else if (kick_ok)
					begin
						wd_cnt_q <= 32'h0;
						early_q  <= 2'h0;
					end
					else if (wd_cnt_q + 32'h1 >= wdu_period_q)
					begin
						wd_q                 <= sswd_pkg::SSWD_WD_FAULT;
						watchdog_fault_out_n <= 1'b0;
						wd_cnt_q             <= 32'h0;
					end
					else
						wd_cnt_q <= wd_cnt_q + 32'h1;
				end
				sswd_pkg::SSWD_WD_FAULT:
				begin
					// Kicks are not looked at in this state
					if (!rst_ok)
					begin
						wd_q                 <= sswd_pkg::SSWD_WD_IDLE;
						watchdog_fault_out_n <= 1'b1;
					end
					else if (wd_cnt_q + 32'h1 >= rst_period_q)
					begin
						wd_q                 <= sswd_pkg::SSWD_WD_WATCH;
						watchdog_fault_out_n <= 1'b1;
						wd_cnt_q             <= 32'h0;
						early_q              <= 2'h0;
					end
					else
						wd_cnt_q <= wd_cnt_q + 32'h1;
				end
				default:
				begin
					wd_q                 <= sswd_pkg::SSWD_WD_IDLE;
					watchdog_fault_out_n <= 1'b1;
					wd_cnt_q             <= 32'h0;
					early_q              <= 2'h0;
				end
			endcase
		end
	end

	// Avalon-MM slave, one wait state per access
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end
		else if ((avs_read || avs_write) && avs_waitrequest)
		begin
			avs_waitrequest <= 1'b0;
			case (avs_address)
				`SSWD_OFF_RST_PERIOD: avs_readdata <= rst_period_q;
				`SSWD_OFF_WDU_PERIOD: avs_readdata <= wdu_period_q;
				`SSWD_OFF_STATUS:
				begin
					avs_readdata                        <= 32'h0;
					avs_readdata[`SSWD_ST_RESET_N]      <= reset_out_n;
					avs_readdata[`SSWD_ST_FAULT_N]      <= watchdog_fault_out_n;
					avs_readdata[`SSWD_ST_VOLT_OK]      <= volt_ok;
					avs_readdata[`SSWD_ST_TIMEOUT_MODE] <= timeout_s;
					avs_readdata[`SSWD_ST_WD_OFF]       <= wd_off_s;
					avs_readdata[`SSWD_ST_BLANK]        <= blank_active;
				end
				default: avs_readdata <= 32'h0;
			endcase
		end
		else
			avs_waitrequest <= 1'b1;
	end

	// Period registers stand in for the timing capacitors
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rst_period_q <= 32'(RST_CYCLES);
			wdu_period_q <= 32'(WDU_CYCLES);
		end
		else if (avs_write && !avs_waitrequest)
		begin
			if (avs_address == `SSWD_OFF_RST_PERIOD)
				rst_period_q <= avs_writedata;
			else if (avs_address == `SSWD_OFF_WDU_PERIOD)
				wdu_period_q <= avs_writedata;
		end
	end

endmodule

`default_nettype wire

/* dv/sswd_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sswd_regs.svh"

module sswd_asserts #(
	parameter int WDU_CYCLES   = 620,
	parameter int RST_CYCLES   = 40,
	parameter int BLANK_CYCLES = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    rst,
	input wire logic                    feedback_sense_above,
	input wire logic                    kick_input,
	input wire logic                    watchdog_off_select,
	input wire logic                    reset_out_n,
	input wire logic                    watchdog_fault_out_n,
	input wire logic [`SSWD_ADDR_W-1:0] avs_address,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [31:0]             avs_readdata,
	input wire logic                    avs_waitrequest
);
	logic [15:0] low_q;
	logic [15:0] flt_q;
	logic [15:0] quiet_q;

	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			low_q <= 16'h0;
		else
			low_q <= reset_out_n ? 16'h0 : low_q + 16'h1;

	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			flt_q <= 16'h0;
		else
			flt_q <= watchdog_fault_out_n ? 16'h0 : flt_q + 16'h1;

	// Any kick edge restarts it, so it only bounds the deadline loosely
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			quiet_q <= 16'h0;
		else if (!reset_out_n || !watchdog_fault_out_n || watchdog_off_select || $changed(kick_input))
			quiet_q <= 16'h0;
		else
			quiet_q <= quiet_q + 16'h1;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_NOT_BOTH_LOW: assert property (reset_out_n || watchdog_fault_out_n)
		else $error("reset and fault low together");
	AST_LOW_VOLT: assert property (!feedback_sense_above [*8] |-> ##[0:8] !reset_out_n)
		else $error("reset not low with voltage low");
	AST_DIP: assert property ($fell(feedback_sense_above) && reset_out_n ##2
		feedback_sense_above [*8] |-> reset_out_n)
		else $error("short dip reached reset");
	AST_RST_PERIOD: assert property ($rose(reset_out_n) |-> low_q >= RST_CYCLES)
		else $error("reset released early");
	AST_FLT_PERIOD: assert property ($rose(watchdog_fault_out_n) && reset_out_n &&
		feedback_sense_above && $past(feedback_sense_above, 12) |->
		flt_q >= RST_CYCLES - 1 && flt_q <= RST_CYCLES + 1)
		else $error("fault low time wrong");
	AST_FAULT_CAUSE: assert property ($fell(watchdog_fault_out_n) |->
		$past(reset_out_n) && !$past(watchdog_off_select, 5))
		else $error("fault while reset low or watchdog off");
	AST_WD_DEADLINE: assert property (quiet_q <= WDU_CYCLES + BLANK_CYCLES + 16)
		else $error("watchdog missed its deadline");
	AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not answered");
	AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address == 4'hC |=>
		avs_readdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind sswd_top sswd_asserts #(.WDU_CYCLES(WDU_CYCLES), .RST_CYCLES(RST_CYCLES),
	.BLANK_CYCLES(BLANK_CYCLES)) i_asserts (.ref_clk, .rst, .feedback_sense_above, .kick_input,
	.watchdog_off_select, .reset_out_n, .watchdog_fault_out_n, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest);
`default_nettype wire

/* dv/sswd_mcu_model.sv */
`timescale 1ns/10ps
`default_nettype none

module sswd_mcu_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [15:0] half_period,
	output var  logic        kick_input
);
	logic [15:0] cnt_q;

	// Stopped processor releases the pin, which its pull-up holds high
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || !run)
		begin
			cnt_q <= 16'h0;
			kick_input <= 1'b1;
		end
		else if (cnt_q + 16'h1 >= half_period)
		begin
			cnt_q <= 16'h0;
			kick_input <= ~kick_input;
		end
		else
			cnt_q <= cnt_q + 16'h1;
	end
endmodule
`default_nettype wire

/* dv/supply_supervisor_watchdog_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sswd_regs.svh"

module supply_supervisor_watchdog_tb;
	logic                    ref_clk, rst, volt, off, mode, run, kick_input;
	logic                    reset_out_n, watchdog_fault_out_n;
	logic [15:0]             half;
	logic [`SSWD_ADDR_W-1:0] avs_address;
	logic                    avs_read, avs_write, avs_waitrequest;
	logic [31:0]             avs_writedata, avs_readdata, q;
	int                      num_errors, check_count, n;

	sswd_top #(.WDU_CYCLES(620), .RST_CYCLES(40), .BLANK_CYCLES(4), .FILT_CYCLES(4)) i_dut (
		.ref_clk, .rst, .feedback_sense_above(volt), .kick_input, .watchdog_off_select(off),
		.timeout_mode_select(mode), .reset_out_n, .watchdog_fault_out_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	sswd_mcu_model i_mcu (.ref_clk, .rst, .run, .half_period(half), .kick_input);

	task automatic wrap_up();
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic fail();
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		wrap_up();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Outputs are read at the falling edge, where they have settled
	task automatic wait_out(input bit flt, input logic v, input int lim, output int k);
		k = 0;
		do
		begin
			@(negedge ref_clk);
			k++;
		end
		while ((flt ? watchdog_fault_out_n : reset_out_n) !== v && k < lim);
		if ((flt ? watchdog_fault_out_n : reset_out_n) !== v)
			fail();
		@(posedge ref_clk);
	endtask

	task automatic hold(input bit flt, input logic v, input int cyc);
		int bad;
		bad = 0;
		repeat (cyc)
		begin
			@(negedge ref_clk);
			bad += ((flt ? watchdog_fault_out_n : reset_out_n) !== v);
		end
		@(posedge ref_clk);
		check(32'(bad), 32'h0);
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Waitrequest and read data as they stood at each rising edge
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 20);
		if (avs_waitrequest !== 1'b0)
			fail();
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Extra edge keeps back-to-back calls from driving twice in one step
		@(posedge ref_clk);
	endtask

	task automatic s_regs();
		bus(1'b1, 4'h0, 32'h28);
		bus(1'b1, 4'h4, 32'h26C);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		bus(1'b0, 4'h0, 32'h0);
		check(q, 32'h28);
		bus(1'b0, 4'h4, 32'h0);
		check(q, 32'h26C);
		bus(1'b0, 4'hC, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		check(q & 32'h3F, 32'h12);
	endtask

	task automatic s_supply();
		hold(1'b0, 1'b0, 100);
		volt <= 1'b1;
		wait_out(1'b0, 1'b1, 200, n);
		check(n >= 40 && n <= 60, 1'b1);
		volt <= 1'b0;
		@(posedge ref_clk);
		@(posedge ref_clk);
		volt <= 1'b1;
		hold(1'b0, 1'b1, 40);
		volt <= 1'b0;
		wait_out(1'b0, 1'b0, 30, n);
		check(n <= 12, 1'b1);
		volt <= 1'b1;
		wait_out(1'b0, 1'b1, 200, n);
	endtask

	task automatic s_train();
		mode <= 1'b1;
		off <= 1'b0;
		wait_out(1'b1, 1'b0, 800, n);
		check(n >= 620, 1'b1);
		wait_out(1'b1, 1'b1, 100, n);
		check(n >= 39 && n <= 41, 1'b1);
		wait_out(1'b1, 1'b0, 800, n);
		check(n >= 620 && n <= 640, 1'b1);
		half <= 16'h5;
		run <= 1'b1;
		wait_out(1'b1, 1'b1, 100, n);
		check(n >= 37 && n <= 41, 1'b1);
		hold(1'b1, 1'b1, 1500);
	endtask

	task automatic s_window();
		half <= 16'h190;
		hold(1'b1, 1'b1, 1500);
		mode <= 1'b0;
		wait_out(1'b1, 1'b0, 1000, n);
		half <= 16'h5;
		wait_out(1'b1, 1'b1, 100, n);
		hold(1'b1, 1'b1, 1500);
		half <= 16'h3;
		wait_out(1'b1, 1'b0, 60, n);
		wait_out(1'b1, 1'b1, 100, n);
	endtask

	task automatic s_off_both();
		run <= 1'b0;
		off <= 1'b1;
		hold(1'b1, 1'b1, 1500);
		off <= 1'b0;
		wait_out(1'b1, 1'b0, 1000, n);
		volt <= 1'b0;
		wait_out(1'b0, 1'b0, 30, n);
		hold(1'b1, 1'b1, 5);
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		volt = 1'b0;
		off = 1'b1;
		mode = 1'b0;
		run = 1'b0;
		half = 16'h5;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		s_regs();
		s_supply();
		s_train();
		s_window();
		s_off_both();
		wrap_up();
	end
endmodule
`default_nettype wire
